// *** hdl/tpwm_pkg.sv ***
package tpwm_pkg;

    // ------------------------------------------------------------------
    // register byte addresses on the apb bus
    // ------------------------------------------------------------------
    localparam logic [7:0] TPWM_ADDR_SC = 8'h00;
    localparam logic [7:0] TPWM_ADDR_CNT = 8'h04;
    localparam logic [7:0] TPWM_ADDR_MOD = 8'h08;
    localparam logic [7:0] TPWM_ADDR_CH0SC = 8'h0c;
    localparam logic [7:0] TPWM_ADDR_CH0V = 8'h10;
    localparam logic [7:0] TPWM_ADDR_CH1SC = 8'h14;
    localparam logic [7:0] TPWM_ADDR_CH1V = 8'h18;
    localparam logic [7:0] TPWM_ADDR_STEP = 8'h08;

    // ------------------------------------------------------------------
    // timer_status_control fields
    // ------------------------------------------------------------------
    localparam int TPWM_SC_OVF_BIT = 7;
    localparam int TPWM_SC_OVIE_BIT = 6;
    localparam int TPWM_SC_CPWM_BIT = 5;
    localparam int TPWM_SC_CLKS_LSB = 3;
    localparam int TPWM_SC_PS_LSB = 0;
    localparam logic [7:0] TPWM_SC_RESET = 8'h00;

    // channel status/control fields
    localparam int TPWM_CH_FLAG_BIT = 7;
    localparam int TPWM_CH_IE_BIT = 6;
    localparam int TPWM_CH_MODE_LSB = 4;
    localparam int TPWM_CH_ELS_LSB = 2;

    // ------------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] TPWM_CLKS_OFF = 2'h0;
    localparam logic [1:0] TPWM_CLKS_BUS = 2'h1;
    localparam logic [1:0] TPWM_CLKS_FIXED = 2'h2;
    localparam logic [1:0] TPWM_CLKS_EXT = 2'h3;
    localparam logic [1:0] TPWM_ELS_TOGGLE = 2'h1;
    localparam logic [1:0] TPWM_ELS_CLEAR = 2'h2;
    localparam logic [1:0] TPWM_ELS_SET = 2'h3;
    localparam logic [1:0] TPWM_MODE_CAPTURE = 2'h0;
    localparam logic [1:0] TPWM_MODE_COMPARE = 2'h1;
    localparam logic [15:0] TPWM_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TPWM_CNT_ONE = 16'h0001;
    localparam logic [15:0] TPWM_MOD_RESET = 16'h0000;
    localparam logic [15:0] TPWM_CV_RESET = 16'h0000;
    localparam int TPWM_CHANNELS = 2;
    localparam int TPWM_PS_BITS = 7;

    typedef struct packed {
        logic ie;
        logic [1:0] mode;
        logic [1:0] els;
    } tpwm_chcfg_s;

    localparam tpwm_chcfg_s TPWM_CHCFG_RESET = '{ie: 1'b0, mode: 2'h0, els: 2'h0};

endpackage : tpwm_pkg

// *** hdl/tpwm_channel.sv ***
`timescale 1ns/1ps

module tpwm_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire tpwm_pkg::tpwm_chcfg_s cfg,
    input wire logic cpwm,
    input wire logic clk_on,
    input wire logic pin_block,
    input wire logic cnt_upd,
    input wire logic count_down,
    input wire logic [15:0] cnt,
    input wire logic cv_wr,
    input wire logic [15:0] cv_wdata,
    input wire logic flag_seen,
    input wire logic flag_wr0,
    input wire logic pin_in,
    output logic [15:0] cv,
    output logic flag,
    output logic pin_out,
    output logic pin_oe_n
);

    // ------------------------------------------------------------------
    // input synchroniser and mode decode
    // ------------------------------------------------------------------
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic arm_r;

    wire els_on = |cfg.els;
    wire cmp_mode = cpwm | (cfg.mode != tpwm_pkg::TPWM_MODE_CAPTURE);
    wire cap_mode = !cmp_mode & els_on & clk_on & !pin_block;
    wire drive = cmp_mode & els_on & clk_on & !pin_block;
    wire rise = sync2_r & !sync3_r;
    wire fall = !sync2_r & sync3_r;
    wire cap_evt = cap_mode & ((cfg.els[0] & rise) | (cfg.els[1] & fall));
    // compare runs with pin action off too, for pure software timing
    wire match = cmp_mode & cnt_upd & (cnt == cv);
    wire period_start = cnt_upd & (cnt == tpwm_pkg::TPWM_CNT_ZERO);
    wire evt = cap_evt | match;
    wire flag_clr = flag_wr0 & arm_r & !evt;
    wire pwm_edge = !cpwm & cfg.mode[1];
    wire oc_mode = !cpwm & (cfg.mode == tpwm_pkg::TPWM_MODE_COMPARE);

    logic pin_nxt;
    always_comb begin
        pin_nxt = pin_out;
        if (!drive) begin
            pin_nxt = sync2_r; // track the pin so toggle starts from its level
        end else if (cpwm) begin
            if (match) begin
                pin_nxt = cfg.els[0] ? !count_down : count_down;
            end
        end else if (pwm_edge) begin
            if (period_start) begin
                pin_nxt = !cfg.els[0];
            end
            if (match) begin
                pin_nxt = cfg.els[0];
            end
        end else if (match) begin
            case (cfg.els)
                tpwm_pkg::TPWM_ELS_TOGGLE: pin_nxt = !pin_out;
                tpwm_pkg::TPWM_ELS_CLEAR: pin_nxt = 1'b0;
                tpwm_pkg::TPWM_ELS_SET: pin_nxt = 1'b1;
                default: pin_nxt = pin_out;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            cv <= tpwm_pkg::TPWM_CV_RESET;
            flag <= 1'b0;
            arm_r <= 1'b0;
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            cv <= cap_evt ? cnt : (cv_wr ? cv_wdata : cv);
            flag <= evt | (flag & !flag_clr);
            arm_r <= !evt & !flag_clr & (arm_r | flag_seen);
            pin_out <= pin_nxt;
            pin_oe_n <= !drive;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
        cap_evt |=> flag && (cv == $past(cnt)))
        else $error("capture did not store the count");
    a_pin_release: assert property (@(posedge pclk) disable iff (!presetn)
        (!els_on || !clk_on) |=> pin_oe_n)
        else $error("pin not released to gpio");
    a_shared_pin: assert property (@(posedge pclk) disable iff (!presetn)
        pin_block |=> pin_oe_n && !$past(cap_evt))
        else $error("shared clock pin driven or captured");
    a_toggle_match: assert property (@(posedge pclk) disable iff (!presetn)
        (drive && oc_mode && cfg.els == tpwm_pkg::TPWM_ELS_TOGGLE && $past(drive) && !match)
        |=> $stable(pin_out))
        else $error("toggle output moved without a match");
    c_capture: cover property (@(posedge pclk) disable iff (!presetn) cap_evt);

endmodule : tpwm_channel

// *** hdl/tpwm_top.sv ***
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// How it works
// - external clock on shared pin stops channel 0 pin use; compare still runs.
// - pin released when edge/level select or clock source select is zero.
// - center select with nonzero edge/level select drives every channel pin as pwm while clocked, except pin 0 on external clock.
// - mode 00, no center select: pin is capture input, edges per select.
// - capture input synchronised to pclk; pulses need four clocks.
// - compare mode toggles, clears or sets pin on each value match.
// - toggle mode keeps previous pin level until the next match.
// - edge pwm, select 10: high at count zero, low on match.
// - edge pwm, low select bit set: low at zero, high on match.
// - center pwm, select 10: clear on up match, set on down match.
// - center pwm, low select bit set: set on up match, clear down.
// - overflow flag bit 7 sets when counter wraps to zero after modulo.
// - flag cleared by read-while-set then write zero; new overflow restarts it.
// - interrupt request when overflow flag and enable bit 6 both set.
// - bit 5 picks up counting or up/down with center pwm on all channels.
// - clock source bits 4..3: off, bus, fixed, external clock.
// - prescaler divides the selected clock by two to the field value.
// - new prescale value acts from the next bus cycle onward.
// - counter restarts at zero after modulo; modulo zero runs free.
// - center mode counts up to modulo, down to zero, repeats.
// - capture edge copies count to channel value and sets channel flag.
module tpwm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_timer_clock_in,
    input wire logic fixed_freq_clock_in,
    input wire logic [1:0] channel_pin_in,
    output logic [1:0] channel_pin_out,
    output logic [1:0] channel_pin_oe_n,
    output logic timer_irq
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [6:0] tpwm_ps_mask(input logic [2:0] ps);
        logic [7:0] one_hot;
        one_hot = 8'h01 << ps;
        return 7'(one_hot - 8'h01);
    endfunction : tpwm_ps_mask

    function automatic logic [31:0] tpwm_ch_word(input tpwm_pkg::tpwm_chcfg_s c,
                                                  input logic f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[tpwm_pkg::TPWM_CH_FLAG_BIT] = f;
        w[tpwm_pkg::TPWM_CH_IE_BIT] = c.ie;
        w[tpwm_pkg::TPWM_CH_MODE_LSB +: 2] = c.mode;
        w[tpwm_pkg::TPWM_CH_ELS_LSB +: 2] = c.els;
        return w;
    endfunction : tpwm_ch_word

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic ovf_flag_r;
    logic ovf_arm_r;
    logic ovf_irq_en_r;
    logic center_align_sel_r;
    logic [1:0] clock_source_sel_r;
    logic [2:0] prescale_sel_r;
    logic [15:0] timer_count_r;
    logic [15:0] modulo_value_r;
    logic count_down_r;
    logic cnt_upd_r;
    logic [6:0] div_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic fix_s1_r;
    logic fix_s2_r;
    logic fix_s3_r;
    tpwm_pkg::tpwm_chcfg_s ch_cfg_r [tpwm_pkg::TPWM_CHANNELS];
    logic [15:0] ch_cv [tpwm_pkg::TPWM_CHANNELS];
    logic [1:0] ch_flag;

    // ------------------------------------------------------------------
    // apb decode: one wait state, effects at the completing edge
    // ------------------------------------------------------------------
    wire access = psel & penable;
    wire done = access & pready;
    wire wr_done = done & pwrite;
    wire rd_done = done & !pwrite;
    wire hit_sc = (paddr == tpwm_pkg::TPWM_ADDR_SC);
    wire hit_cnt = (paddr == tpwm_pkg::TPWM_ADDR_CNT);
    wire hit_mod = (paddr == tpwm_pkg::TPWM_ADDR_MOD);
    wire [1:0] hit_chsc;
    wire [1:0] hit_chv;
    assign hit_chsc[0] = (paddr == tpwm_pkg::TPWM_ADDR_CH0SC);
    assign hit_chsc[1] = (paddr == tpwm_pkg::TPWM_ADDR_CH1SC);
    assign hit_chv[0] = (paddr == tpwm_pkg::TPWM_ADDR_CH0V);
    assign hit_chv[1] = (paddr == tpwm_pkg::TPWM_ADDR_CH1V);
    wire mapped = hit_sc | hit_cnt | hit_mod | (|hit_chsc) | (|hit_chv);
    wire sc_wr = wr_done & hit_sc;
    wire wr_zero_flag = !pwdata[tpwm_pkg::TPWM_SC_OVF_BIT];

    wire [7:0] sc_word = {ovf_flag_r, ovf_irq_en_r, center_align_sel_r,
                          clock_source_sel_r, prescale_sel_r};
    wire [31:0] rd_word =
        hit_sc ? {24'h000000, sc_word} :
        hit_cnt ? {16'h0000, timer_count_r} :
        hit_mod ? {16'h0000, modulo_value_r} :
        hit_chsc[0] ? tpwm_ch_word(ch_cfg_r[0], ch_flag[0]) :
        hit_chsc[1] ? tpwm_ch_word(ch_cfg_r[1], ch_flag[1]) :
        hit_chv[0] ? {16'h0000, ch_cv[0]} :
        hit_chv[1] ? {16'h0000, ch_cv[1]} : 32'h0000_0000;

    // ------------------------------------------------------------------
    // clock selection and prescaler
    // ------------------------------------------------------------------
    // external and fixed clocks are edge-sampled, hence the quarter-rate limit
    wire ext_edge = ext_s2_r & !ext_s3_r;
    wire fix_edge = fix_s2_r & !fix_s3_r;
    wire clk_on = (clock_source_sel_r != tpwm_pkg::TPWM_CLKS_OFF);
    wire src_tick =
        (clock_source_sel_r == tpwm_pkg::TPWM_CLKS_BUS) ? 1'b1 :
        (clock_source_sel_r == tpwm_pkg::TPWM_CLKS_FIXED) ? fix_edge :
        (clock_source_sel_r == tpwm_pkg::TPWM_CLKS_EXT) ? ext_edge : 1'b0;
    // mask read straight from the register: a new value acts next cycle
    wire [6:0] ps_mask = tpwm_ps_mask(prescale_sel_r);
    wire tick = src_tick & ((div_r & ps_mask) == ps_mask);
    wire ext_shares_pin = (clock_source_sel_r == tpwm_pkg::TPWM_CLKS_EXT);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    wire at_mod = (timer_count_r == modulo_value_r);
    wire at_zero = (timer_count_r == tpwm_pkg::TPWM_CNT_ZERO);
    wire [15:0] cnt_inc = timer_count_r + tpwm_pkg::TPWM_CNT_ONE;
    wire [15:0] cnt_dec = timer_count_r - tpwm_pkg::TPWM_CNT_ONE;
    logic [15:0] cnt_nxt;
    logic down_nxt;
    logic ovf_evt;

    always_comb begin
        cnt_nxt = timer_count_r;
        down_nxt = count_down_r & center_align_sel_r;
        ovf_evt = 1'b0;
        if (tick) begin
            if (!center_align_sel_r) begin
                // free running when modulo is zero: wrap after all ones
                if (at_mod && !at_zero) begin
                    cnt_nxt = tpwm_pkg::TPWM_CNT_ZERO;
                    ovf_evt = 1'b1;
                end else begin
                    cnt_nxt = cnt_inc;
                    ovf_evt = (cnt_inc == tpwm_pkg::TPWM_CNT_ZERO);
                end
            end else if (!count_down_r) begin
                if (at_mod) begin
                    down_nxt = !at_zero;
                    cnt_nxt = at_zero ? timer_count_r : cnt_dec;
                    ovf_evt = at_zero;
                end else begin
                    cnt_nxt = cnt_inc;
                end
            end else if (at_zero) begin
                down_nxt = 1'b0;
                cnt_nxt = cnt_inc;
            end else begin
                cnt_nxt = cnt_dec;
                ovf_evt = (cnt_dec == tpwm_pkg::TPWM_CNT_ZERO);
            end
        end
        if (wr_done && hit_cnt) begin
            cnt_nxt = tpwm_pkg::TPWM_CNT_ZERO;
            down_nxt = 1'b0;
            ovf_evt = 1'b0;
        end
    end

    // hardware set beats the software clear in the same cycle
    wire ovf_clr = sc_wr & wr_zero_flag & ovf_arm_r & !ovf_evt;
    wire ovf_flag_nxt = ovf_evt | (ovf_flag_r & !ovf_clr);
    wire sc_seen = rd_done & hit_sc & prdata[tpwm_pkg::TPWM_SC_OVF_BIT];
    wire ovf_arm_nxt = !ovf_evt & !ovf_clr & (ovf_arm_r | sc_seen);
    wire ch_irq0 = ch_flag[0] & ch_cfg_r[0].ie;
    wire ch_irq1 = ch_flag[1] & ch_cfg_r[1].ie;
    // enable taken at its next value so the request never lags a write of it
    wire ovf_ie_nxt = sc_wr ? pwdata[tpwm_pkg::TPWM_SC_OVIE_BIT] : ovf_irq_en_r;
    wire irq_nxt = (ovf_flag_nxt & ovf_ie_nxt) | ch_irq0 | ch_irq1;

    // ------------------------------------------------------------------
    // flops
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access & !pready;
            pslverr <= access & !pready & !mapped;
            prdata <= (access && !pready && !pwrite) ? rd_word : prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_r <= 1'b0;
            ovf_arm_r <= 1'b0;
            timer_irq <= 1'b0;
            timer_count_r <= tpwm_pkg::TPWM_CNT_ZERO;
            count_down_r <= 1'b0;
            cnt_upd_r <= 1'b0;
        end else begin
            ovf_flag_r <= ovf_flag_nxt;
            ovf_arm_r <= ovf_arm_nxt;
            timer_irq <= irq_nxt;
            timer_count_r <= cnt_nxt;
            count_down_r <= down_nxt;
            cnt_upd_r <= tick;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ovf_irq_en_r, center_align_sel_r} <= 2'h0;
            clock_source_sel_r <= tpwm_pkg::TPWM_CLKS_OFF;
            prescale_sel_r <= 3'h0;
        end else if (sc_wr) begin
            ovf_irq_en_r <= pwdata[tpwm_pkg::TPWM_SC_OVIE_BIT];
            center_align_sel_r <= pwdata[tpwm_pkg::TPWM_SC_CPWM_BIT];
            clock_source_sel_r <= pwdata[tpwm_pkg::TPWM_SC_CLKS_LSB +: 2];
            prescale_sel_r <= pwdata[tpwm_pkg::TPWM_SC_PS_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 7'h00;
            modulo_value_r <= tpwm_pkg::TPWM_MOD_RESET;
            {ext_s1_r, ext_s2_r, ext_s3_r} <= 3'h0;
            {fix_s1_r, fix_s2_r, fix_s3_r} <= 3'h0;
        end else begin
            div_r <= (wr_done && hit_cnt) ? 7'h00 : (src_tick ? div_r + 7'h01 : div_r);
            modulo_value_r <= (wr_done && hit_mod) ? pwdata[15:0] : modulo_value_r;
            {ext_s1_r, ext_s2_r, ext_s3_r} <= {ext_timer_clock_in, ext_s1_r, ext_s2_r};
            {fix_s1_r, fix_s2_r, fix_s3_r} <= {fixed_freq_clock_in, fix_s1_r, fix_s2_r};
        end
    end

    // ------------------------------------------------------------------
    // channels: pin 0 doubles as the external clock pin
    // ------------------------------------------------------------------
    for (genvar g = 0; g < tpwm_pkg::TPWM_CHANNELS; g++) begin : g_ch
        wire chsc_wr = wr_done & hit_chsc[g];
        wire ch_seen = rd_done & hit_chsc[g] & prdata[tpwm_pkg::TPWM_CH_FLAG_BIT];
        wire ch_wr0 = chsc_wr & !pwdata[tpwm_pkg::TPWM_CH_FLAG_BIT];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ch_cfg_r[g] <= tpwm_pkg::TPWM_CHCFG_RESET;
            end else if (chsc_wr) begin
                ch_cfg_r[g] <= pwdata[tpwm_pkg::TPWM_CH_ELS_LSB +: 5];
            end
        end

        tpwm_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .cfg(ch_cfg_r[g]),
            .cpwm(center_align_sel_r),
            .clk_on(clk_on),
            .pin_block(ext_shares_pin && (g == 0)),
            .cnt_upd(cnt_upd_r),
            .count_down(count_down_r),
            .cnt(timer_count_r),
            .cv_wr(wr_done & hit_chv[g]),
            .cv_wdata(pwdata[15:0]),
            .flag_seen(ch_seen),
            .flag_wr0(ch_wr0),
            .pin_in(channel_pin_in[g]),
            .cv(ch_cv[g]),
            .flag(ch_flag[g]),
            .pin_out(channel_pin_out[g]),
            .pin_oe_n(channel_pin_oe_n[g])
        );
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_ovf_sets: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_evt |=> ovf_flag_r && (timer_count_r == 16'h0000))
        else $error("overflow did not set the flag at zero");
    a_zero_needs_read: assert property (@(posedge pclk) disable iff (!presetn)
        (sc_wr && !ovf_arm_r && ovf_flag_r) |=> ovf_flag_r)
        else $error("flag cleared without an arming read");
    a_clear_seq: assert property (@(posedge pclk) disable iff (!presetn)
        (sc_wr && wr_zero_flag && ovf_arm_r && !ovf_evt) |=> !ovf_flag_r)
        else $error("armed zero write did not clear the flag");
    a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (ovf_flag_r && ovf_irq_en_r) |-> timer_irq)
        else $error("overflow interrupt not requested");
    a_mod_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !center_align_sel_r && at_mod && !at_zero && !(wr_done && hit_cnt))
        |=> timer_count_r == 16'h0000)
        else $error("counter did not restart after modulo");
    a_clock_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!clk_on && !(wr_done && hit_cnt)) |=> $stable(timer_count_r))
        else $error("counter moved with no clock source");
    a_div_two: assert property (@(posedge pclk) disable iff (!presetn)
        (prescale_sel_r == 3'h1 && tick && !sc_wr) |=> !tick)
        else $error("divide-by-two ticked on two cycles in a row");
    a_center_turn: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && center_align_sel_r && !count_down_r && at_mod && !at_zero
         && !(wr_done && hit_cnt)) |=> count_down_r)
        else $error("center count did not turn at modulo");
    c_overflow: cover property (@(posedge pclk) disable iff (!presetn) ovf_evt);
    c_clear: cover property (@(posedge pclk) disable iff (!presetn) ovf_clr);
    c_center: cover property (@(posedge pclk) disable iff (!presetn)
        center_align_sel_r && count_down_r && tick);

endmodule : tpwm_top

// *** tb/tpwm_pins.sv ***
`timescale 1ns/1ps

module tpwm_pins (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] gpio_lvl,
    output logic ext_clk,
    output logic fix_clk,
    output logic [1:0] pin_in
);
    // ----
    // far-side clocks and pin wires
    // ----
    logic [2:0] div_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_r <= 3'h0;
        else div_r <= div_r + 3'h1;
    end
    // pclk/8 stays well under the quarter-rate limit
    assign ext_clk = div_r[2];
    assign fix_clk = div_r[2];
    // released pin shows the gpio side, held many cycles at a time
    assign pin_in = (pin_oe_n & gpio_lvl) | (~pin_oe_n & pin_out);
endmodule : tpwm_pins

// *** tb/test_timer_pwm_pin_and_control.sv ***
`timescale 1ns/1ps

module test_timer_pwm_pin_and_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ext_clk, fix_clk, timer_irq;
    logic [1:0] pin_in, pin_out, pin_oe_n;
    logic [1:0] gpio_lvl = 2'h3;
    logic [31:0] seed = 32'h00014828;
    int errors = 0, checks_done = 0, cyc = 0, hi, n;
    tpwm_top tpwm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_timer_clock_in(ext_clk), .fixed_freq_clock_in(fix_clk),
        .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe_n(pin_oe_n),
        .timer_irq(timer_irq));
    tpwm_pins tpwm_pins_i (.pclk(pclk), .presetn(presetn), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .gpio_lvl(gpio_lvl), .ext_clk(ext_clk), .fix_clk(fix_clk),
        .pin_in(pin_in));
    // ----
    // helpers
    // ----
    initial forever #5 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // loose window: clock phase and sync delay blur a few ticks
    function automatic logic in_win(input logic [31:0] c, input int n, input int d);
        return c >= (n - 16) / d && c <= (n + 16) / d + 1;
    endfunction : in_win
    function automatic int pwm_high(input int i, input int m, input int v);
        int p;
        p = (i < 2) ? m + 1 : 2 * m;
        if (i == 4) return 72;
        return (144 / p) * ((i == 0) ? v : (i == 1) ? p - v : (i == 2) ? 2 * v : p - 2 * v);
    endfunction : pwm_high
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_of_test;
        end
    end
    // ----
    // scenarios
    // ----
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h00, 32'h08);
        repeat (20) @(posedge pclk);
        apb(1'b1, 8'h00, 32'hc0);
        repeat (2) @(negedge pclk);
        chk(timer_irq, 1'b1);
        apb(1'b1, 8'h00, 32'h40);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'hc0);
        apb(1'b1, 8'h00, 32'h40);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h40);
        repeat (2) @(negedge pclk);
        chk(timer_irq, 1'b0);
        apb(1'b1, 8'h08, 32'h0);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            n = 64 + int'(seed[7:0]);
            gpio_lvl <= seed[9:8];
            apb(1'b1, 8'h04, 32'h0);
            apb(1'b1, 8'h00, (i < 8) ? (32'h08 | i) : ((i == 8) ? 32'h10 : 32'h18));
            repeat (n) @(posedge pclk);
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b0, 8'h04, 32'h0);
            chk(in_win(rd, n, (i < 8) ? (1 << i) : 8), 1'b1);
        end
        gpio_lvl <= 2'h0;
        apb(1'b1, 8'h18, 32'h1234);
        apb(1'b1, 8'h14, 32'h04);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h0f);
        repeat (8) @(posedge pclk);
        gpio_lvl <= 2'h2;
        repeat (4) @(posedge pclk);
        gpio_lvl <= 2'h0;
        repeat (4) @(posedge pclk);
        chk(pin_oe_n[1], 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h84);
        apb(1'b1, 8'h08, 32'h8);
        apb(1'b1, 8'h10, 32'h5);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h0c, (i == 4) ? 32'h14 : ((i % 2) ? 32'h24 : 32'h28));
            apb(1'b1, 8'h00, (i == 2 || i == 3) ? 32'h28 : 32'h08);
            repeat (40) @(negedge pclk);
            hi = 0;
            repeat (144) begin
                @(negedge pclk);
                hi += int'(pin_out[0]);
            end
            chk(pin_oe_n[0], 1'b0);
            chk(hi, pwm_high(i, 8, 5));
        end
        apb(1'b1, 8'h00, 32'h18);
        repeat (3) @(negedge pclk);
        chk(pin_oe_n[0], 1'b1);
        apb(1'b1, 8'h00, 32'h08);
        apb(1'b1, 8'h0c, 32'h20);
        repeat (3) @(negedge pclk);
        chk(pin_oe_n[0], 1'b1);
        end_of_test;
    end
endmodule : test_timer_pwm_pin_and_control
